// [design/spsy_port.v]
// Purpose: serial peripheral port, master or slave, with register sync monitor
// Assumes: spi mode 0, msb first; link pins are foreign to clk
// Notes:   register port follows apb signalling with one wait state
`timescale 1ns/100ps
`include "spsy_map.vh"

module spsy_port (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // register port
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // serial clock pin
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe,
    // select pin, active low
    input  wire        ss_n_in,
    output reg         ss_n_out,
    output reg         ss_n_oe,
    // master out pin
    input  wire        mosi_in,
    output reg         mosi_out,
    output reg         mosi_oe,
    // master in pin
    input  wire        miso_in,
    output reg         miso_out,
    output reg         miso_oe
);

localparam LK_IDLE = 1'b0;
localparam LK_RUN  = 1'b1;

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg        en;
reg        en_pend;
reg        master;
reg [1:0]  ctl_b;
reg [1:0]  ctl_b_pend;
reg [7:0]  baud;
reg        sw_busy;
reg        en_busy;
reg        cb_busy;
reg [3:0]  sync_cnt;
reg        srst;
reg [8:0]  tx_hold;
reg        tx_valid;
reg        txc;
reg        ovf_flag;
reg        lk_state;
reg [7:0]  hp_cnt;
reg [8:0]  tx_sh;
reg [8:0]  rx_sh;
reg [3:0]  bitcnt;
reg        sck_d;
reg        ss_d;
reg        m_end;
reg        rx_push;
reg [8:0]  rx_char;
reg [8:0]  next_tx_sh;
wire [3:0] pin_s;
wire       sck_s = pin_s[0];
wire       ss_s  = pin_s[1];
wire       mosi_s = pin_s[2];
wire       miso_s = pin_s[3];
wire [8:0] rx_rd;
wire       rx_ne;
wire       rx_ovf;
wire       rd_pop;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [3:0] char_len;
    input chsize;
    begin
        char_len = chsize ? `SPSY_CHAR_LONG : `SPSY_CHAR_SHORT;
    end
endfunction

function [8:0] align_char;
    input       chsize;
    input [8:0] d;
    begin
        align_char = chsize ? d : {d[7:0], 1'b0};
    end
endfunction

function addr_known;
    input [7:0] a;
    begin
        if (a == `SPSY_ADDR_CTL_A)
            addr_known = 1'b1;
        else if (a == `SPSY_ADDR_CTL_B)
            addr_known = 1'b1;
        else if (a == `SPSY_ADDR_BAUD)
            addr_known = 1'b1;
        else if (a == `SPSY_ADDR_STATUS)
            addr_known = 1'b1;
        else if (a == `SPSY_ADDR_BUSY)
            addr_known = 1'b1;
        else if (a == `SPSY_ADDR_DATA)
            addr_known = 1'b1;
        else
            addr_known = 1'b0;
    end
endfunction

// ----------------------------------------------------------------
// pin synchronisers and buffer
// ----------------------------------------------------------------
spsy_sync2 #(
    .W (4)
) spsy_sync2_i (
    .clk  (clk),
    .nrst (nrst),
    .d    ({miso_in, mosi_in, ss_n_in, sck_in}),
    .q    (pin_s)
);

spsy_rxbuf #(
    .W (9)
) spsy_rxbuf_i (
    .clk       (clk),
    .nrst      (nrst),
    .clr       (srst),
    .push      (rx_push),
    .push_data (rx_char),
    .ovf       (rx_ovf),
    .pop       (rd_pop),
    .rd_data   (rx_rd),
    .not_empty (rx_ne)
);

// ----------------------------------------------------------------
// access decode
// ----------------------------------------------------------------
wire acc      = psel && penable && !pready;
wire wr       = acc && pwrite;
wire is_ctl_a = (paddr == `SPSY_ADDR_CTL_A);
wire is_ctl_b = (paddr == `SPSY_ADDR_CTL_B);
wire rst_wr   = is_ctl_a && pwdata[`SPSY_CTL_A_SRST];
// soft reset sync blocks every write; enable sync all but reset
wire wr_drop  = sw_busy || (en_busy && !rst_wr);
wire wr_err   = wr && (wr_drop || (is_ctl_b && cb_busy)
                || !addr_known(paddr));
wire wr_ok    = wr && !wr_err;
assign rd_pop = acc && !pwrite && (paddr == `SPSY_ADDR_DATA) && rx_ne;
wire data_wr  = wr_ok && (paddr == `SPSY_ADDR_DATA);
wire [31:0] sb_word = {29'h0, cb_busy, en_busy, sw_busy};
wire [31:0] st_word = {28'h0, ovf_flag, rx_ne, txc, !tx_valid};

// ----------------------------------------------------------------
// link events
// ----------------------------------------------------------------
wire slave_on = en && !master && !ss_s;
wire ss_fall  = en && !master && ss_d && !ss_s;
wire m_tick   = master && (lk_state == LK_RUN) && (hp_cnt == 8'h00);
wire rise_ev  = master ? (m_tick && !sck_out) : (slave_on && !sck_d && sck_s);
wire fall_ev  = master ? (m_tick && sck_out) : (slave_on && sck_d && !sck_s);
wire start_ev = en && master && (lk_state == LK_IDLE) && tx_valid;
wire last_bit = (bitcnt == char_len(ctl_b[0]) - 4'd1);
wire load_now = start_ev || ss_fall
                || (fall_ev && (bitcnt == 4'd0) && (!master || tx_valid));
wire consume  = load_now && tx_valid;
wire char_end = rise_ev && last_bit;

// ----------------------------------------------------------------
// register side
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        en         <= 1'b0;
        en_pend    <= 1'b0;
        master     <= 1'b0;
        ctl_b      <= `SPSY_RST_CTL_B;
        ctl_b_pend <= `SPSY_RST_CTL_B;
        baud       <= `SPSY_RST_BAUD;
        sw_busy    <= 1'b0;
        en_busy    <= 1'b0;
        cb_busy    <= 1'b0;
        sync_cnt   <= 4'h0;
        srst       <= 1'b0;
        tx_hold    <= 9'h000;
        tx_valid   <= 1'b0;
        txc        <= 1'b0;
        ovf_flag   <= 1'b0;
        pready     <= 1'b0;
        pslverr    <= 1'b0;
        prdata     <= 32'h0;
    end
    else
    begin
        pready  <= acc;
        pslverr <= acc && (wr_err || (!pwrite && !addr_known(paddr)));
        srst    <= 1'b0;
        if (acc && !pwrite)
        begin
            if (is_ctl_a)
                prdata <= {29'h0, master, en_pend, sw_busy};
            else if (is_ctl_b)
                prdata <= {30'h0, ctl_b};
            else if (paddr == `SPSY_ADDR_BAUD)
                prdata <= {24'h0, baud};
            else if (paddr == `SPSY_ADDR_STATUS)
                prdata <= st_word;
            else if (paddr == `SPSY_ADDR_BUSY)
                prdata <= sb_word;
            else if (paddr == `SPSY_ADDR_DATA)
                prdata <= {23'h0, rx_rd};
            else
                prdata <= 32'h0;
        end
        // sync completion applies pending values
        if (sync_cnt != 4'h0)
        begin
            sync_cnt <= sync_cnt - 4'h1;
            if (sync_cnt == 4'h1)
            begin
                en      <= en_pend;
                ctl_b   <= ctl_b_pend;
                sw_busy <= 1'b0;
                en_busy <= 1'b0;
                cb_busy <= 1'b0;
                srst    <= sw_busy;
            end
        end
        if (srst)
        begin
            en         <= 1'b0;
            en_pend    <= 1'b0;
            master     <= 1'b0;
            ctl_b      <= `SPSY_RST_CTL_B;
            ctl_b_pend <= `SPSY_RST_CTL_B;
            baud       <= `SPSY_RST_BAUD;
            tx_valid   <= 1'b0;
            txc        <= 1'b0;
            ovf_flag   <= 1'b0;
        end
        else
        begin
            // write wins over consume so no char is lost
            if (data_wr)
            begin
                tx_hold  <= pwdata[8:0];
                tx_valid <= 1'b1;
            end
            else if (consume)
                tx_valid <= 1'b0;
            // hardware set beats software clear
            if (m_end || (char_end && !tx_valid))
                txc <= 1'b1;
            else if (wr_ok && (paddr == `SPSY_ADDR_STATUS) && pwdata[`SPSY_ST_TXC])
                txc <= 1'b0;
            if (rx_ovf)
                ovf_flag <= 1'b1;
            else if (wr_ok && (paddr == `SPSY_ADDR_STATUS) && pwdata[`SPSY_ST_OVF])
                ovf_flag <= 1'b0;
        end
        if (wr_ok && is_ctl_a)
        begin
            if (rst_wr)
            begin
                sw_busy  <= 1'b1;
                sync_cnt <= `SPSY_SYNC_CYCLES;
            end
            else
            begin
                if (!en && !en_pend)
                    master <= pwdata[`SPSY_CTL_A_MASTER];
                if (pwdata[`SPSY_CTL_A_ENABLE] != en_pend)
                begin
                    en_pend  <= pwdata[`SPSY_CTL_A_ENABLE];
                    en_busy  <= 1'b1;
                    sync_cnt <= `SPSY_SYNC_CYCLES;
                end
            end
        end
        if (wr_ok && is_ctl_b)
        begin
            ctl_b_pend <= pwdata[1:0];
            if (en)
            begin
                cb_busy  <= 1'b1;
                sync_cnt <= `SPSY_SYNC_CYCLES;
            end
            else
                ctl_b <= pwdata[1:0];
        end
        if (wr_ok && (paddr == `SPSY_ADDR_BAUD) && !en && !en_pend)
            baud <= pwdata[7:0];
    end
end

// ----------------------------------------------------------------
// shift register next value
// ----------------------------------------------------------------
always @*
begin
    next_tx_sh = tx_sh;
    if (load_now)
        next_tx_sh = tx_valid ? align_char(ctl_b[0], tx_hold) : 9'h000;
    else if (fall_ev)
        next_tx_sh = {tx_sh[7:0], 1'b0};
end

// ----------------------------------------------------------------
// link side
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        lk_state <= LK_IDLE;
        hp_cnt   <= 8'h00;
        tx_sh    <= 9'h000;
        rx_sh    <= 9'h000;
        bitcnt   <= 4'h0;
        sck_d    <= 1'b0;
        ss_d     <= 1'b1;
        m_end    <= 1'b0;
        rx_push  <= 1'b0;
        rx_char  <= 9'h000;
        sck_out  <= 1'b0;
        sck_oe   <= 1'b0;
        ss_n_out <= 1'b1;
        ss_n_oe  <= 1'b0;
        mosi_out <= 1'b0;
        mosi_oe  <= 1'b0;
        miso_out <= 1'b0;
        miso_oe  <= 1'b0;
    end
    else
    begin
        sck_d   <= sck_s;
        ss_d    <= ss_s;
        m_end   <= 1'b0;
        rx_push <= 1'b0;
        // only the master drives clock, select and mosi
        sck_oe   <= en && master;
        ss_n_oe  <= en && master;
        mosi_oe  <= en && master;
        miso_oe  <= slave_on;
        tx_sh    <= next_tx_sh;
        mosi_out <= master && next_tx_sh[8];
        miso_out <= !master && next_tx_sh[8];
        if (!en || srst || (!master && ss_s))
        begin
            // deselect restarts bit counting
            lk_state <= LK_IDLE;
            bitcnt   <= 4'h0;
            sck_out  <= 1'b0;
            ss_n_out <= 1'b1;
        end
        else
        begin
            if (start_ev)
            begin
                lk_state <= LK_RUN;
                hp_cnt   <= baud;
                ss_n_out <= 1'b0;
                bitcnt   <= 4'h0;
            end
            else if (lk_state == LK_RUN)
                hp_cnt <= (hp_cnt == 8'h00) ? baud : hp_cnt - 8'h01;
            if (m_tick)
                sck_out <= !sck_out;
            if (rise_ev)
            begin
                // sample the far line: miso as master, mosi as slave
                rx_sh <= {rx_sh[7:0], master ? miso_s : mosi_s};
                if (last_bit)
                begin
                    bitcnt  <= 4'h0;
                    rx_push <= ctl_b[`SPSY_CTL_B_RXEN];
                    rx_char <= ctl_b[0] ? {rx_sh[7:0], master ? miso_s : mosi_s}
                                        : {1'b0, rx_sh[6:0], master ? miso_s : mosi_s};
                end
                else
                    bitcnt <= bitcnt + 4'h1;
            end
            if (fall_ev && master && (bitcnt == 4'd0) && !tx_valid)
            begin
                // nothing queued: close the transaction
                lk_state <= LK_IDLE;
                ss_n_out <= 1'b1;
                m_end    <= 1'b1;
            end
        end
    end
end

endmodule

// [design/spsy_map.vh]
// Purpose: register map, field positions, reset values and counts of the serial port
// Assumes: 32-bit register port, one aligned word per register
// Notes:   definitions only
`ifndef SPSY_MAP_VH
`define SPSY_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPSY_ADDR_CTL_A    8'h00
`define SPSY_ADDR_CTL_B    8'h04
`define SPSY_ADDR_BAUD     8'h0c
`define SPSY_ADDR_STATUS   8'h18
`define SPSY_ADDR_BUSY     8'h1c
`define SPSY_ADDR_DATA     8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPSY_CTL_A_SRST    0
`define SPSY_CTL_A_ENABLE  1
`define SPSY_CTL_A_MASTER  2
`define SPSY_CTL_B_CHSIZE  0
`define SPSY_CTL_B_RXEN    1
`define SPSY_ST_DRE        0
`define SPSY_ST_TXC        1
`define SPSY_ST_RXC        2
`define SPSY_ST_OVF        3
`define SPSY_SB_SRST       0
`define SPSY_SB_ENABLE     1
`define SPSY_SB_CONTROL_B_REGISTER      2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SPSY_RST_CTL_B     2'h2
`define SPSY_RST_BAUD      8'h03
`define SPSY_SYNC_CYCLES   4'h3
`define SPSY_CHAR_SHORT    4'h8
`define SPSY_CHAR_LONG     4'h9

`endif

// [design/spsy_sync2.v]
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are slow levels relative to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps

module spsy_sync2 #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk,
    input  wire         nrst,
    // levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

// ----------------------------------------------------------------
// two stages
// ----------------------------------------------------------------
reg [W-1:0] meta;

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        meta <= {W{1'b0}};
        q    <= {W{1'b0}};
    end
    else
    begin
        meta <= d;
        q    <= meta;
    end
end

endmodule

// [design/spsy_rxbuf.v]
// Purpose: two-level receive buffer
// Assumes: push and pop are single-cycle pulses
// Notes:   push into a full buffer without a pop drops the char and pulses ovf
`timescale 1ns/100ps

module spsy_rxbuf #(
    parameter W = 9
) (
    // clock and reset
    input  wire         clk,
    input  wire         nrst,
    input  wire         clr,
    // fill side
    input  wire         push,
    input  wire [W-1:0] push_data,
    output reg          ovf,
    // drain side
    input  wire         pop,
    output wire [W-1:0] rd_data,
    output wire         not_empty
);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg [W-1:0] mem [0:1];
reg         wp;
reg         rp;
reg [1:0]   cnt;
wire        do_pop  = pop && (cnt != 2'd0);
wire        do_push = push && ((cnt != 2'd2) || do_pop);

assign rd_data   = mem[rp];
assign not_empty = (cnt != 2'd0);

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        mem[0] <= {W{1'b0}};
        mem[1] <= {W{1'b0}};
        wp     <= 1'b0;
        rp     <= 1'b0;
        cnt    <= 2'd0;
        ovf    <= 1'b0;
    end
    else if (clr)
    begin
        wp  <= 1'b0;
        rp  <= 1'b0;
        cnt <= 2'd0;
        ovf <= 1'b0;
    end
    else
    begin
        ovf <= push && !do_push;
        if (do_push)
        begin
            mem[wp] <= push_data;
            wp      <= ~wp;
        end
        if (do_pop)
            rp <= ~rp;
        if (do_push && !do_pop)
            cnt <= cnt + 2'd1;
        else if (do_pop && !do_push)
            cnt <= cnt - 2'd1;
    end
end

endmodule

// [tb/spsy_port_chk.sv]
// Purpose: port-level assertions for the serial port
// Assumes: one clock domain, clk with async nrst
// Notes:   bound to every instance of the port below the module
`timescale 1ns/100ps
`include "spsy_map.vh"

module spsy_port_chk (
    // clock and reset
    input logic        clk,
    input logic        nrst,
    // register port
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // link pins
    input logic        sck_in,
    input logic        sck_out,
    input logic        sck_oe,
    input logic        ss_n_in,
    input logic        ss_n_out,
    input logic        ss_n_oe,
    input logic        mosi_in,
    input logic        mosi_out,
    input logic        mosi_oe,
    input logic        miso_in,
    input logic        miso_out,
    input logic        miso_oe
);
    // ------------------------------------------------
    // taken writes
    // ------------------------------------------------
    wire tk  = psel & penable & ~pready & pwrite;
    wire sw  = tk & (paddr == `SPSY_ADDR_CTL_A) & pwdata[0];
    // sck_oe marks an enabled master, so this write must change enable
    wire dis = tk & (paddr == `SPSY_ADDR_CTL_A) & ~pwdata[0] & ~pwdata[1] & sck_oe;
    wire cbw = tk & (paddr == `SPSY_ADDR_CTL_B);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_role; miso_oe |-> !sck_oe && !mosi_oe; endproperty
    a_role: assert property (p_role) else $error("slave and master drive at once");
    property p_sck_idle; !sck_oe |-> !sck_out; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck high while undriven");
    property p_sck_frame; $rose(sck_out) |-> !ss_n_out && ss_n_oe; endproperty
    a_sck_frame: assert property (p_sck_frame) else $error("sck edge outside select");
    property p_ss_end; $rose(ss_n_out) |-> !sck_out; endproperty
    a_ss_end: assert property (p_ss_end) else $error("select rose with sck high");
    property p_deselect; ss_n_in [*6] |-> !miso_oe; endproperty
    a_deselect: assert property (p_deselect) else $error("miso driven while deselected");
    property p_busy_ro; pready && psel && !pwrite && paddr == `SPSY_ADDR_BUSY |-> prdata[31:3] == 29'h0;
    endproperty
    a_busy_ro: assert property (p_busy_ro) else $error("busy register upper bits set");
    property p_soft_reset_request_err; sw ##3 tk |=> pready && pslverr; endproperty
    a_soft_reset_request_err: assert property (p_soft_reset_request_err) else $error("write during reset sync accepted");
    property p_enable_err; dis ##3 (tk && paddr != `SPSY_ADDR_CTL_A) |=> pslverr; endproperty
    a_enable_err: assert property (p_enable_err) else $error("write during enable sync accepted");
    property p_control_b_register_err; (cbw && sck_oe) ##3 cbw |=> pslverr; endproperty
    a_control_b_register_err: assert property (p_control_b_register_err) else $error("control b rewrite accepted");
    property p_err_pair; pslverr |-> pready; endproperty
    a_err_pair: assert property (p_err_pair) else $error("error without ready");
endmodule

bind spsy_port spsy_port_chk spsy_port_chk_i (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out),
    .ss_n_oe(ss_n_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe)
);

// [tb/spsy_slave_model.sv]
// Purpose: behavioural far-side slave for master-mode traffic
// Assumes: mode 0, msb first, 8 or 9 bit chars
// Notes:   keeps the first char of a frame in rx0 and the latest char in rx1
`timescale 1ns/100ps

module spsy_slave_model (
    // link
    input  wire       sck,
    input  wire       ss_n,
    input  wire       mosi,
    output reg        miso,
    // bench side
    input  wire [3:0] nbits,
    input  wire [8:0] tx0,
    input  wire [8:0] tx1,
    output reg  [8:0] rx0,
    output reg  [8:0] rx1
);
    reg [8:0] sh;
    reg [8:0] rsh;
    int       bitn;
    int       ch;

    initial miso = 1'b0;
    // select low opens the frame, first bit preloaded
    always @(negedge ss_n)
    begin
        bitn = 0;
        ch = 0;
        sh = tx0;
        miso = tx0[nbits - 1];
    end
    always @(posedge sck)
        if (!ss_n)
        begin
            rsh = {rsh[7:0], mosi};
            bitn++;
            if (bitn == nbits)
            begin
                if (ch == 0) rx0 = rsh & ((9'h1 << nbits) - 9'h1);
                else rx1 = rsh & ((9'h1 << nbits) - 9'h1);
                ch++;
                bitn = 0;
                sh = tx1;
            end
        end
    always @(negedge sck)
        if (!ss_n) miso = sh[nbits - 1 - bitn];
    // released line: no stale level left behind
    always @(posedge ss_n) miso = ~miso;
endmodule

// [tb/spsy_port_tb_top.sv]
// Purpose: self-checking bench for the serial port
// Assumes: reset baud, slave model on the far side
// Notes:   sync waits of 6 cycles cover the 3-cycle sync
`timescale 1ns/100ps
`include "spsy_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module spsy_port_tb_top;
    localparam [7:0] CA = `SPSY_ADDR_CTL_A, CB = `SPSY_ADDR_CTL_B, BD = `SPSY_ADDR_BAUD;
    localparam [7:0] ST = `SPSY_ADDR_STATUS, SB = `SPSY_ADDR_BUSY, DT = `SPSY_ADDR_DATA;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, mo;
    logic [31:0] pwdata, prdata, rd;
    logic        sck_out, sck_oe, ss_n_out, ss_n_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic        tb_sck, tb_ss_n, tb_mosi;
    wire         slv_miso;
    logic [8:0]  tx0, tx1, got;
    wire  [8:0]  rx0, rx1;
    logic [3:0]  nbits;
    int          mismatches, n_compared;
    int          cyc = 0;
    // pin levels from the port's enables; bench and slave model drive otherwise
    wire sck_w  = sck_oe ? sck_out : tb_sck;
    wire ss_w   = ss_n_oe ? ss_n_out : tb_ss_n;
    wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire miso_w = miso_oe ? miso_out : slv_miso;

    spsy_port spsy_port_i (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .ss_n_in(ss_w), .ss_n_out(ss_n_out),
        .ss_n_oe(ss_n_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe));
    spsy_slave_model spsy_slave_model_i (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(slv_miso),
        .nbits(nbits), .tx0(tx0), .tx1(tx1), .rx0(rx0), .rx1(rx1));

    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            complete_run;
        end
    end

    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    // psel stays up between transfers so no signal is driven twice per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        `CHK(er, e)
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
        `CHK(er, 1'b0)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ST, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 100);
        `CHK(rd[b], 1'b1)
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task t_map;
        rdc(SB, 32'h0);
        wr(SB, 32'h7, 1'b0);
        rdc(SB, 32'h0);
        rdc(CB, 32'h2);
        rdc(BD, 32'h3);
        wr(8'h40, 32'h1, 1'b1);
        $display("test map done");
    endtask
    task t_enable;
        wr(CA, 32'h6, 1'b0);
        rdc(SB, 32'h2);
        wt(6);
        wr(CA, 32'h4, 1'b0);
        wr(BD, 32'h0, 1'b1);
        wt(6);
        wr(CA, 32'h6, 1'b0);
        wt(6);
        wr(BD, 32'h0, 1'b0);
        rdc(BD, 32'h3);
        $display("test enable done");
    endtask
    task t_master;
        tx0 = 9'h03c;
        tx1 = 9'h0c3;
        wr(DT, 32'ha5, 1'b0);
        poll(`SPSY_ST_DRE);
        wr(DT, 32'h5a, 1'b0);
        poll(`SPSY_ST_TXC);
        `CHK(rx0, 9'h0a5)
        `CHK(rx1, 9'h05a)
        // third char finds both receive slots full
        wr(DT, 32'h11, 1'b0);
        poll(`SPSY_ST_OVF);
        wr(ST, 32'h8, 1'b0);
        rdc(DT, 32'h3c);
        rdc(DT, 32'hc3);
        apb(1'b0, ST, 32'h0);
        `CHK(rd[`SPSY_ST_RXC], 1'b0)
        `CHK(rd[`SPSY_ST_OVF], 1'b0)
        $display("test master done");
    endtask
    task t_nine;
        wr(CB, 32'h3, 1'b0);
        wr(CB, 32'h3, 1'b1);
        wt(6);
        wr(CB, 32'h3, 1'b0);
        rdc(SB, 32'h4);
        wt(6);
        rdc(CB, 32'h3);
        nbits = 4'h9;
        tx0 = 9'h1c3;
        wr(ST, 32'h2, 1'b0);
        wr(DT, 32'h1a5, 1'b0);
        poll(`SPSY_ST_TXC);
        `CHK(rx0, 9'h1a5)
        rdc(DT, 32'h1c3);
        $display("test nine done");
    endtask
    task t_soft_reset;
        wr(CA, 32'h1, 1'b0);
        rdc(SB, 32'h1);
        wt(6);
        wr(CA, 32'h1, 1'b0);
        wr(CB, 32'h0, 1'b1);
        wt(6);
        rdc(SB, 32'h0);
        rdc(CA, 32'h0);
        rdc(CB, 32'h2);
        $display("test soft reset done");
    endtask
    task t_slave;
        mo = 8'h69;
        wr(DT, 32'h96, 1'b0);
        wr(CA, 32'h2, 1'b0);
        wt(6);
        // stray clocks while deselected must not build a char
        repeat (16)
        begin
            tb_sck <= ~tb_sck;
            wt(4);
        end
        tb_ss_n <= 1'b0;
        wt(8);
        for (int i = 7; i >= 0; i--)
        begin
            tb_mosi <= mo[i];
            wt(4);
            got[i] = miso_w;
            tb_sck <= 1'b1;
            wt(4);
            tb_sck <= 1'b0;
        end
        wt(4);
        tb_ss_n <= 1'b1;
        tb_mosi <= ~mo[0];
        wt(8);
        `CHK(got[7:0], 8'h96)
        rdc(DT, 32'h69);
        apb(1'b0, ST, 32'h0);
        `CHK(rd[`SPSY_ST_RXC], 1'b0)
        $display("test slave done");
    endtask

    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tb_sck = 1'b0;
        tb_ss_n = 1'b1;
        tb_mosi = 1'b0;
        nbits = 4'h8;
        tx0 = 9'h0;
        tx1 = 9'h0;
        mismatches = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_map;
        t_enable;
        t_master;
        t_nine;
        t_soft_reset;
        t_slave;
        complete_run;
    end
endmodule
